// ===== rtl/sst_pkg.sv
// package: power state encodings and configuration constants for the sleep state sequencer
package sst_pkg;

  // ----------------------------------------------------------------
  // power states, gray coded along sleep, soft-off and mechanical-off
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SST_G3   = 3'h0,
    SST_S0C0 = 3'h1,
    SST_S0CX = 3'h3,
    SST_S3   = 3'h2,
    SST_S4   = 3'h6,
    SST_S5   = 3'h7,
    SST_DEEP = 3'h5,
    SST_RSV  = 3'h4
  } sst_state_e;

  // ----------------------------------------------------------------
  // sleep request encodings on sleep_type
  // ----------------------------------------------------------------
  localparam logic [1:0] SLP_TYPE_S3 = 2'h1;
  localparam logic [1:0] SLP_TYPE_S4 = 2'h2;
  localparam logic [1:0] SLP_TYPE_S5 = 2'h3;

  // ----------------------------------------------------------------
  // plane enable vector layout and reset values
  // ----------------------------------------------------------------
  localparam int PLANE_CPU = 0;
  localparam int PLANE_MAIN = 1;
  localparam int PLANE_MEM = 2;
  localparam int PLANE_SUS = 3;
  localparam int PLANE_W = 4;
  localparam logic [3:0] PLANES_RESET = 4'h0;
  localparam int WAKE_W = 8;
  localparam logic [7:0] WAKE_RESET = 8'h00;

endpackage

// ===== rtl/sst_sleep_seq.sv
// module: system sleep state transition sequencer
`timescale 1ns/1ps
// Operation
// [RULE1] S0 to S4 may pass through S3 as an unlisted intermediate step.
// [RULE2] Keep enabled preservable wake events across a power failure.
// [RULE3] Mobile: defer any S3/S4/S5/G3 to S0 move while battery low.
// [RULE4] Override or forced-off events drive and keep the system in soft-off.
// [RULE5] Override S5 entry continues into deep sleep when enabled and allowed.
// [RULE6] Power return from G3 reboots to S0 or stays soft-off until wake.
// [RULE7] Coming from S4 before G3, power return goes to S0 or S4.
// [RULE8] Reboot choice uses prior state and the after-power-loss select bit.
// [RULE9] Deep sleep exit resumes to the S3, S4 or S5 it came from.
// [RULE10] Enabled wake in sleep or soft-off moves to S0, deferred by battery low.
module sst_sleep_seq #(
  parameter int WAKE_W = sst_pkg::WAKE_W
) (
  // clock and reset (reset models power loss of suspend logic)
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // platform inputs
  input  wire logic                       power_ok,
  input  wire logic                       battery_low_n,
  input  wire logic                       mobile_cfg,
  input  wire logic                       after_power_loss_select,
  input  wire logic                       override_evt,
  input  wire logic                       cpu_idle_cx,
  // sleep request from software
  input  wire logic                       sleep_req,
  input  wire logic [1:0]                 sleep_type,
  // wake events
  input  wire logic [WAKE_W-1:0]          wake_evt,
  input  wire logic [WAKE_W-1:0]          wake_en,
  input  wire logic [WAKE_W-1:0]          wake_keep,
  // deep sleep control
  input  wire logic                       deep_en,
  input  wire logic                       deep_cond_ok,
  input  wire logic                       deep_exit,
  // state, plane and wake defer outputs
  output logic [2:0]                      state,
  output logic [sst_pkg::PLANE_W-1:0]     plane_en,
  output logic                            wake_defer
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power state and where it came from
  sst_pkg::sst_state_e state_q, state_d;
  sst_pkg::sst_state_e deep_from_q, deep_from_d;
  sst_pkg::sst_state_e pre_g3_q, pre_g3_d;
  // kept wakes, planes and override entry marker
  logic [WAKE_W-1:0] wake_hold_q, wake_hold_d;
  logic [sst_pkg::PLANE_W-1:0] plane_q, plane_d;
  logic ovr_q, ovr_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [WAKE_W-1:0] wake_live = wake_evt & wake_en;
  wire logic wake_any = (|wake_live) | (|wake_hold_q);
  wire logic bat_block = mobile_cfg & ~battery_low_n; // RULE3
  wire logic in_sleep = (state_q == sst_pkg::SST_S3) | (state_q == sst_pkg::SST_S4) |
                        (state_q == sst_pkg::SST_S5) | (state_q == sst_pkg::SST_G3);
  wire logic in_s0 = (state_q == sst_pkg::SST_S0C0) | (state_q == sst_pkg::SST_S0CX);
  wire logic deep_go = deep_en & deep_cond_ok;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    deep_from_d = deep_from_q;
    pre_g3_d = pre_g3_q;
    ovr_d = 1'b0;
    // preservable wake events survive power failure; new ones are ORed into the held set
    wake_hold_d = wake_hold_q | (wake_live & wake_keep); // RULE2
    if (!power_ok) begin
      if (state_q != sst_pkg::SST_G3) begin
        pre_g3_d = state_q;
      end
      state_d = sst_pkg::SST_G3;
    end else begin
      case (state_q)
        sst_pkg::SST_S0C0, sst_pkg::SST_S0CX: begin
          if (override_evt) begin
            state_d = sst_pkg::SST_S5; // RULE4
            ovr_d = 1'b1;
          end else if (sleep_req) begin
            case (sleep_type)
              sst_pkg::SLP_TYPE_S3: state_d = sst_pkg::SST_S3;
              // S4 entry steps through S3 first
              sst_pkg::SLP_TYPE_S4: state_d = sst_pkg::SST_S3; // RULE1
              sst_pkg::SLP_TYPE_S5: state_d = sst_pkg::SST_S5;
              default: state_d = state_q;
            endcase
          end else begin
            state_d = cpu_idle_cx ? sst_pkg::SST_S0CX : sst_pkg::SST_S0C0;
          end
        end
        sst_pkg::SST_S3, sst_pkg::SST_S4, sst_pkg::SST_S5: begin
          if (override_evt && (state_q != sst_pkg::SST_S5)) begin
            state_d = sst_pkg::SST_S5; // RULE4
            ovr_d = 1'b1;
          end else if (ovr_q && deep_go) begin
            deep_from_d = state_q;
            state_d = sst_pkg::SST_DEEP; // RULE5
          end else if (wake_any && !override_evt) begin
            if (!bat_block) begin
              state_d = sst_pkg::SST_S0C0; // RULE10
              wake_hold_d = '0;
            end
          end else if (state_q == sst_pkg::SST_S3 && sleep_req &&
                       sleep_type == sst_pkg::SLP_TYPE_S4) begin
            state_d = sst_pkg::SST_S4; // RULE1
          end
        end
        sst_pkg::SST_DEEP: begin
          if (deep_exit || wake_any) begin
            state_d = deep_from_q; // RULE9
          end
        end
        sst_pkg::SST_G3: begin
          // power back: choose by prior state and select bit
          if (pre_g3_q == sst_pkg::SST_S4) begin
            state_d = after_power_loss_select ? sst_pkg::SST_S4 : // RULE7
                      (bat_block ? sst_pkg::SST_S4 : sst_pkg::SST_S0C0);
          end else if (after_power_loss_select) begin
            state_d = sst_pkg::SST_S5; // RULE6
          end else if (!bat_block) begin
            state_d = sst_pkg::SST_S0C0; // RULE8
          end
        end
        default: state_d = sst_pkg::SST_S5;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // plane enables per next state
  // ----------------------------------------------------------------
  wire logic [sst_pkg::PLANE_W-1:0] planes_soff;
  wire logic [sst_pkg::PLANE_W-1:0] planes_str;
  wire logic [sst_pkg::PLANE_W-1:0] planes_full;

  // plane sets: suspend only, then memory, then everything
  assign planes_soff = sst_pkg::PLANES_RESET | (4'h1 << sst_pkg::PLANE_SUS);
  assign planes_str = planes_soff | (4'h1 << sst_pkg::PLANE_MEM);
  assign planes_full = planes_str | (4'h1 << sst_pkg::PLANE_MAIN) | (4'h1 << sst_pkg::PLANE_CPU);

  // select the plane set of the state being entered
  always_comb begin
    plane_d = sst_pkg::PLANES_RESET;
    case (state_d)
      sst_pkg::SST_S0C0, sst_pkg::SST_S0CX: plane_d = planes_full;
      sst_pkg::SST_S3: plane_d = planes_str;
      sst_pkg::SST_S4, sst_pkg::SST_S5: plane_d = planes_soff;
      default: plane_d = sst_pkg::PLANES_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers; reset is loss of suspend power
  // ----------------------------------------------------------------
  // power state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= sst_pkg::SST_G3;
    end else begin
      state_q <= state_d;
    end
  end

  // state that deep sleep was entered from
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      deep_from_q <= sst_pkg::SST_S5;
    end else begin
      deep_from_q <= deep_from_d;
    end
  end

  // state held just before mechanical-off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_g3_q <= sst_pkg::SST_S5;
    end else begin
      pre_g3_q <= pre_g3_d;
    end
  end

  // wakes kept across power failure
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_hold_q <= sst_pkg::WAKE_RESET;
    end else begin
      wake_hold_q <= wake_hold_d;
    end
  end

  // plane enables, aligned with the state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      plane_q <= sst_pkg::PLANES_RESET;
    end else begin
      plane_q <= plane_d;
    end
  end

  // one-cycle pulse after soft-off entry by override, for deep sleep entry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign state = state_q;
  assign plane_en = plane_q;
  assign wake_defer = bat_block & in_sleep & wake_any & ~in_s0; // RULE3

endmodule // sst_sleep_seq

// ===== sim/sst_sleep_seq_assertions.sv
// checker: power state sequencing properties
`timescale 1ns/1ps
module sst_sleep_seq_chk #(parameter int WAKE_W = 8) (
  // watched ports
  input wire logic              clk_sys, rst, power_ok, battery_low_n, mobile_cfg,
  input wire logic              after_power_loss_select, override_evt, deep_en,
  input wire logic              deep_cond_ok, deep_exit,
  input wire logic [WAKE_W-1:0] wake_evt, wake_en,
  input wire logic [2:0]        state,
  input wire logic [3:0]        plane_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // battery block and state decodes
  wire blk = mobile_cfg && !battery_low_n;
  wire s0  = state == sst_pkg::SST_S0C0;
  wire s5  = state == sst_pkg::SST_S5;
  wire g3  = state == sst_pkg::SST_G3;
  wire dp  = state == sst_pkg::SST_DEEP;
  wire slp = state == sst_pkg::SST_S3 || state == sst_pkg::SST_S4 || s5;
  // override from full on, then deep allowed
  sequence s_ovr; power_ok && override_evt && s0; endsequence
  sequence s_deep; power_ok && deep_en && deep_cond_ok && s5; endsequence
  chk_pwr_fail: assert property (!power_ok |=> g3) else $error("no G3");
  chk_force_off: assert property (power_ok && override_evt && !g3 && !dp
    && !(s5 && deep_en && deep_cond_ok) |=> s5) else $error("override");
  chk_batt_defer: assert property (power_ok && blk && (slp || g3) |=> !s0)
    else $error("batt");
  chk_wake_on: assert property (power_ok && !override_evt && !deep_en && !blk && slp
    && |(wake_evt & wake_en) |=> s0) else $error("wake");
  chk_deep_entry: assert property (s_ovr ##1 s_deep |=> dp) else $error("deep");
  chk_deep_exit: assert property (power_ok && !override_evt && deep_exit && dp |=> s5)
    else $error("exit");
  chk_g3_reboot: assert property (power_ok && g3 && !after_power_loss_select && !blk
    |=> s0) else $error("reboot");
  chk_g3_stay: assert property (power_ok && g3 && after_power_loss_select
    |=> s5 || state == sst_pkg::SST_S4) else $error("stay");
  chk_plane_map: assert property (plane_en == (s0 || state == sst_pkg::SST_S0CX ? 4'hF
    : state == sst_pkg::SST_S3 ? 4'hC : slp ? 4'h8 : 4'h0)) else $error("planes");
endmodule // sst_sleep_seq_chk
bind sst_sleep_seq sst_sleep_seq_chk #(.WAKE_W(WAKE_W)) i_chk (.clk_sys(clk_sys), .rst(rst),
  .power_ok(power_ok), .battery_low_n(battery_low_n), .mobile_cfg(mobile_cfg),
  .after_power_loss_select(after_power_loss_select), .override_evt(override_evt),
  .deep_en(deep_en), .deep_cond_ok(deep_cond_ok), .deep_exit(deep_exit),
  .wake_evt(wake_evt), .wake_en(wake_en), .state(state), .plane_en(plane_en));

// ===== sim/sst_platform.sv
// platform model: mains supply, battery and power button
`timescale 1ns/1ps
module sst_platform (
  // stimulus
  input wire logic clk_sys, mains_on, batt_low, button_hold,
  // platform signals
  output logic     power_ok, battery_low_n, override_evt
);
  logic [1:0] hold_q;
  // button must be held past three edges to force off
  always_ff @(posedge clk_sys) hold_q <= button_hold ? hold_q + {1'b0, hold_q != 2'h3} : 2'h0;
  assign override_evt = button_hold && hold_q == 2'h3;
  assign power_ok = mains_on;
  assign battery_low_n = !batt_low;
endmodule // sst_platform

// ===== sim/sst_sleep_seq_tb.sv
// testbench: sleep state sequencer
`timescale 1ns/1ps
module sst_sleep_seq_tb;
  typedef struct {logic ovr, slp; logic [1:0] st; logic wk; logic [2:0] ex;} sst_row_s;
  logic clk_sys = 0, rst = 1, mains_on = 1, batt_low = 0, button_hold = 0, sel = 0;
  logic mobile_cfg = 0, sleep_req = 0, deep_en = 0, deep_cond_ok = 0, deep_exit = 0;
  logic cpu_idle = 0;
  logic power_ok, battery_low_n, override_evt, wake_defer;
  logic [1:0] sleep_type = 0;
  logic [7:0] wake_evt = 0, wake_en = 8'hFF, wake_keep = 0;
  logic [2:0] state;
  logic [3:0] plane_en;
  int err_count = 0, n_tests = 0, cyc_n = 0;
  // one step per row: inputs, then the state they should give
  sst_row_s rows [8] = '{'{0, 0, 0, 0, sst_pkg::SST_S0C0}, '{0, 1, 1, 0, sst_pkg::SST_S3},
    '{0, 0, 0, 1, sst_pkg::SST_S0C0}, '{0, 1, 2, 0, sst_pkg::SST_S3},
    '{0, 1, 2, 0, sst_pkg::SST_S4}, '{0, 0, 0, 1, sst_pkg::SST_S0C0},
    '{1, 0, 0, 0, sst_pkg::SST_S5}, '{0, 0, 0, 1, sst_pkg::SST_S0C0}};
  sst_platform i_plat (.clk_sys(clk_sys), .mains_on(mains_on), .batt_low(batt_low),
    .button_hold(button_hold), .power_ok(power_ok), .battery_low_n(battery_low_n),
    .override_evt(override_evt));
  sst_sleep_seq i_dut (.clk_sys(clk_sys), .rst(rst), .power_ok(power_ok),
    .battery_low_n(battery_low_n), .mobile_cfg(mobile_cfg), .after_power_loss_select(sel),
    .override_evt(override_evt), .cpu_idle_cx(cpu_idle), .sleep_req(sleep_req),
    .sleep_type(sleep_type), .wake_evt(wake_evt), .wake_en(wake_en), .wake_keep(wake_keep),
    .deep_en(deep_en), .deep_cond_ok(deep_cond_ok), .deep_exit(deep_exit), .state(state),
    .plane_en(plane_en), .wake_defer(wake_defer));
  task automatic cyc(int n = 1); repeat (n) @(negedge clk_sys); endtask
  task automatic check(logic [3:0] seen, logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // state and its plane set
  task automatic expect_st(logic [2:0] e);
    check({1'b0, state}, {1'b0, e});
    check(plane_en, e inside {1, 3} ? 4'hF : e == 2 ? 4'hC : e inside {6, 7} ? 4'h8 : 4'h0);
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // clock and hang guard
  initial forever #20 clk_sys = !clk_sys;
  always @(posedge clk_sys) if (++cyc_n == 3000) begin err_count++; report_and_stop; end
  initial begin
    cyc(4);
    rst = 0;
    foreach (rows[i]) begin
      button_hold = rows[i].ovr; sleep_req = rows[i].slp; sleep_type = rows[i].st;
      wake_evt = {7'h0, rows[i].wk};
      if (rows[i].ovr) cyc(3);
      cyc;
      expect_st(rows[i].ex);
    end
    button_hold = 0; sleep_req = 0; wake_evt = 0; $display("table done");
    deep_en = 1; deep_cond_ok = 1; button_hold = 1; cyc(4); button_hold = 0;
    cyc; expect_st(sst_pkg::SST_DEEP);
    deep_exit = 1; cyc; deep_exit = 0; deep_en = 0;
    expect_st(sst_pkg::SST_S5); $display("deep done");
    mobile_cfg = 1; batt_low = 1; wake_keep = 8'hFF; wake_evt = 8'h04; cyc;
    expect_st(sst_pkg::SST_S5); check({3'h0, wake_defer}, 4'h1);
    wake_evt = 0; mains_on = 0; cyc; expect_st(sst_pkg::SST_G3);
    sel = 1; mains_on = 1; batt_low = 0; cyc(2);
    expect_st(sst_pkg::SST_S0C0); $display("kept wake done");
    sleep_req = 1; sleep_type = sst_pkg::SLP_TYPE_S4; cyc(2); sleep_req = 0;
    mains_on = 0; cyc; mains_on = 1; cyc; expect_st(sst_pkg::SST_S4);
    mains_on = 0; sel = 0; batt_low = 1; cyc; mains_on = 1; cyc;
    expect_st(sst_pkg::SST_S4);
    batt_low = 0; wake_evt = 8'h01; cyc; expect_st(sst_pkg::SST_S0C0);
    $display("power return done");
    wake_evt = 0; wake_keep = 0; cpu_idle = 1; cyc; expect_st(sst_pkg::SST_S0CX);
    button_hold = 1; cyc(4); expect_st(sst_pkg::SST_S5);
    wake_evt = 8'h02; cyc; expect_st(sst_pkg::SST_S5);
    button_hold = 0; wake_en = 8'h00; cpu_idle = 0; cyc; expect_st(sst_pkg::SST_S5);
    check({3'h0, wake_defer}, 4'h0);
    batt_low = 1; mobile_cfg = 0; wake_en = 8'hFF; cyc; expect_st(sst_pkg::SST_S0C0);
    wake_evt = 0; batt_low = 0; sleep_req = 1; sleep_type = sst_pkg::SLP_TYPE_S5; cyc;
    sleep_req = 0; expect_st(sst_pkg::SST_S5);
    wake_evt = 8'h80; cyc; wake_evt = 0; expect_st(sst_pkg::SST_S0C0);
    sleep_req = 1; sleep_type = sst_pkg::SLP_TYPE_S3; cyc; sleep_req = 0;
    expect_st(sst_pkg::SST_S3);
    button_hold = 1; cyc(4); button_hold = 0; expect_st(sst_pkg::SST_S5);
    $display("override and sleep types done");
    sel = 0; rst = 1; cyc(2); expect_st(sst_pkg::SST_G3);
    rst = 0; cyc; expect_st(sst_pkg::SST_S0C0);
    $display("mid-run reset done");
    report_and_stop;
  end
endmodule // sst_sleep_seq_tb
